// File: hw/upw_pkg.sv
package upw_pkg;

  // Pin-usage field encodings
  localparam logic [1:0] UPW_USE_TXRX    = 2'h0;
  localparam logic [1:0] UPW_USE_RTS     = 2'h1;
  localparam logic [1:0] UPW_USE_RTS_CTS = 2'h2;
  localparam logic [1:0] UPW_USE_BCLK    = 2'h3;

  // Reset values
  localparam logic       UPW_WAKE_RST    = 1'h0;
  localparam logic       UPW_IRQ_RST     = 1'h0;

  // Control bits, driven by the register file outside this block
  typedef struct packed {
    logic       module_enable;
    logic       transmit_enable_bit;
    logic       receive_enable_bit;
    logic [1:0] pin_usage_field;
    logic       stop_in_idle_bit;
    logic       loopback_enable_bit;
    logic       receive_irq_enable;
  } upw_ctrl_t;

  // Signals from the core UART engine
  typedef struct packed {
    logic tx_data;
    logic rts_level;
    logic baud16;
    logic rx_irq_req;
  } upw_core_t;

  // Pin drive: value and output enable per pin
  typedef struct packed {
    logic tx_o;
    logic tx_oe;
    logic rts_bclk_o;
    logic rts_bclk_oe;
  } upw_pins_t;

endpackage : upw_pkg

// File: hw/upw_pin_power_wake.sv
// What this block does
// - With enable, transmit and receive enabled, take pins per pin-usage field.
// - Owned pins: serial out is an output, serial in an input.
// - Flow control: clear-to-send is input, shared pin drives request-to-send.
// - Baud-clock selection drives shared pin with sixteen-times baud clock.
// - Sleep entry stops UART, aborts transmit, drives serial out high.
// - Sleep entry aborts any reception in progress.
// - During sleep request-to-send and baud-clock pins are driven low.
// - Wake set and receive irq enabled: falling receive edge raises receive irq.
// - Wake-up interrupt only while module enable is set.
// - Idle with stop-in-idle acts as sleep; otherwise runs normally.
// - While wake set, suppress reception and hold UART engine idle.
// - Wake event is a high-to-low receive edge, watched in every mode except loopback.
// - Receive irq flag set synchronously to i_clk in every mode, sleep included.
// - Wake bit clears itself on next rising receive edge after wake.
// - Wake event sets receive irq flag regardless of irq select field.
// - Wake edge detection samples the synchronised pin and needs i_clk running.
// - Device or power-on reset returns registers to reset values.
// - Watchdog reset holds wake bit and receive irq flag; pin and core control registers keep updating.
// - Request-to-send driven as output when pin-usage is 01 or 10.
// - Pin-usage 11 and enabled: output sixteen-times baud clock.
module upw_pin_power_wake
  import upw_pkg::*;
(
  // Clock and resets
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  input  wire logic            i_wdt_rst,
  // Power state
  input  wire logic            i_sleep,
  input  wire logic            i_idle,
  // Configuration and software access
  input  wire upw_pkg::upw_ctrl_t i_ctrl,
  input  wire logic            i_wake_set,
  input  wire logic            i_wake_clr,
  input  wire logic            i_irq_clr,
  // Core engine
  input  wire upw_pkg::upw_core_t i_core,
  // Pins
  input  wire logic            i_serial_in_pin,
  input  wire logic            i_clear_to_send_pin,
  // Outputs
  output logic                 o_serial_out_pin,
  output logic                 o_serial_out_oe,
  output logic                 o_rts_bclk_pin,
  output logic                 o_rts_bclk_oe,
  output logic                 o_cts,
  output logic                 o_rx_data,
  output logic                 o_core_run,
  output logic                 o_core_abort,
  output logic                 o_port_override,
  output logic                 o_wake_bit,
  output logic                 o_receive_irq_flag
);
  import upw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic rx_s1;
  logic rx_s2;
  logic rx_d;
  logic cts_s1;
  logic cts_s2;

  always_ff @(posedge i_clk) begin
    rx_s1  <= i_serial_in_pin;
    rx_s2  <= rx_s1;
    rx_d   <= rx_s2;
    cts_s1 <= i_clear_to_send_pin;
    cts_s2 <= cts_s1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire owned     = i_ctrl.module_enable & i_ctrl.transmit_enable_bit
                   & i_ctrl.receive_enable_bit;
  wire halted    = i_sleep | (i_idle & i_ctrl.stop_in_idle_bit);
  wire use_rts   = (i_ctrl.pin_usage_field == UPW_USE_RTS) |
                   (i_ctrl.pin_usage_field == UPW_USE_RTS_CTS);
  wire use_cts   = i_ctrl.pin_usage_field == UPW_USE_RTS_CTS;
  wire use_bclk  = i_ctrl.pin_usage_field == UPW_USE_BCLK;
  // Edge seen from synced pin; assumes the clock keeps running in sleep
  wire fall_rx   = rx_d & ~rx_s2;
  wire rise_rx   = ~rx_d & rx_s2;
  logic wake_seen;

  // Wake event: edge seen while wake armed and module on
  wire wake_evt  = o_wake_bit & ~wake_seen & fall_rx & i_ctrl.module_enable
                   & ~i_ctrl.loopback_enable_bit;
  wire irq_set   = wake_evt ? i_ctrl.receive_irq_enable
                 : (i_core.rx_irq_req & ~halted & ~o_wake_bit);

  // Pin drive selection
  wire next_tx    = halted ? 1'b1 : i_core.tx_data;
  wire shared_val = halted ? 1'b0
                  : use_bclk ? i_core.baud16
                  : i_core.rts_level;
  wire shared_oe  = owned & (use_rts | (use_bclk & i_ctrl.module_enable));

  ////////////////////////////////////////////////////////////////////////////
  // Wake and flag state; watchdog reset keeps registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wake_bit         <= UPW_WAKE_RST;
      wake_seen          <= 1'b0;
      o_receive_irq_flag <= UPW_IRQ_RST;
    end else if (!i_wdt_rst) begin
      if (wake_evt) begin
        wake_seen <= 1'b1;
      end else if (wake_seen && rise_rx) begin
        wake_seen <= 1'b0;
      end
      if (i_wake_set) begin
        o_wake_bit <= 1'b1;
      end else if ((wake_seen && rise_rx) || i_wake_clr) begin
        o_wake_bit <= 1'b0;
      end
      // Set wins over software clear
      if (irq_set) begin
        o_receive_irq_flag <= 1'b1;
      end else if (i_irq_clr) begin
        o_receive_irq_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and core control registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_serial_out_pin <= 1'b1;
      o_serial_out_oe  <= 1'b0;
      o_rts_bclk_pin   <= 1'b0;
      o_rts_bclk_oe    <= 1'b0;
      o_cts            <= 1'b0;
      o_rx_data        <= 1'b1;
      o_core_run       <= 1'b0;
      o_core_abort     <= 1'b0;
      o_port_override  <= 1'b0;
    end else begin
      o_port_override  <= owned;
      o_serial_out_oe  <= owned;
      o_serial_out_pin <= next_tx;
      o_rts_bclk_oe    <= shared_oe;
      o_rts_bclk_pin   <= shared_val;
      o_cts            <= use_cts ? cts_s2 : 1'b0;
      o_rx_data        <= o_wake_bit ? 1'b1 : rx_s2;
      o_core_run       <= owned & ~halted & ~o_wake_bit;
      o_core_abort     <= halted;
    end
  end

endmodule : upw_pin_power_wake

// File: test/upw_checker.sv
module upw_checker
  import upw_pkg::*;
(
  input wire logic              i_clk,
  input wire logic              i_rst,
  input wire logic              i_wdt_rst,
  input wire logic              i_sleep,
  input wire logic              i_idle,
  input wire upw_pkg::upw_ctrl_t i_ctrl,
  input wire upw_pkg::upw_core_t i_core,
  input wire logic              i_serial_in_pin,
  input wire logic              o_serial_out_pin,
  input wire logic              o_rts_bclk_pin,
  input wire logic              o_cts,
  input wire logic              o_rx_data,
  input wire logic              o_core_run,
  input wire logic              o_wake_bit,
  input wire logic              o_receive_irq_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire logic halt = i_sleep || (i_idle && i_ctrl.stop_in_idle_bit);
  wire logic own  = &i_ctrl[7:5];
  // Wake armed: enabled module, irq enabled, loopback off
  wire logic arm  = o_wake_bit && i_ctrl[7] && i_ctrl[0] && !i_ctrl[1];
  halt_tx_a: assert property (halt |=> o_serial_out_pin) else $error("tx not high");
  halt_rts_a: assert property (halt |=> !o_rts_bclk_pin) else $error("rts not low");
  halt_stop_a: assert property (halt |=> !o_core_run) else $error("core runs");
  cts_mode_a: assert property (i_ctrl.pin_usage_field != UPW_USE_RTS_CTS |=> !o_cts)
    else $error("cts passed");
  bclk_out_a: assert property (own && !halt && i_ctrl.pin_usage_field == UPW_USE_BCLK
    |=> o_rts_bclk_pin == $past(i_core.baud16)) else $error("bclk wrong");
  wake_rx_a: assert property (o_wake_bit && $past(o_wake_bit) |-> o_rx_data)
    else $error("rx not quiet");
  wake_irq_a: assert property ($fell(i_serial_in_pin) && arm |-> ##[1:5] o_receive_irq_flag)
    else $error("no wake irq");
  wdt_hold_a: assert property (i_wdt_rst |=> $stable(o_wake_bit) && $stable(o_receive_irq_flag))
    else $error("wdt changed state");
  rst_clear_a: assert property (disable iff (1'b0) i_rst |=> !o_wake_bit && !o_receive_irq_flag)
    else $error("reset left state");
endmodule : upw_checker

bind upw_pin_power_wake upw_checker u_upw_checker (.*);

// File: test/upw_far_end.sv
// Remote node: line idles high, pulls low for a break
module upw_far_end (
  input  wire logic i_clk,
  input  wire logic i_brk,
  output logic      o_rx = 1'b1,
  output logic      o_cts = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge i_clk) begin
    o_rx  <= !i_brk;
    o_cts <= !o_cts;
  end
endmodule : upw_far_end

// File: test/uart_pin_power_wake_control_tb.sv
module uart_pin_power_wake_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import upw_pkg::*;
  logic clk, rst, wdt, slp, idl, wset, wclr, iclr, brk, rx, cts, h, own;
  logic tx, txoe, rb, rboe, ocs, rxd, run, abt, ovr, wk, flg;
  upw_ctrl_t ctl;
  upw_core_t core;
  int error_cnt, check_count, cyc;
  upw_pin_power_wake u_upw_pin_power_wake (.i_clk(clk), .i_rst(rst), .i_wdt_rst(wdt),
    .i_sleep(slp), .i_idle(idl), .i_ctrl(ctl), .i_wake_set(wset), .i_wake_clr(wclr),
    .i_irq_clr(iclr), .i_core(core), .i_serial_in_pin(rx), .i_clear_to_send_pin(cts),
    .o_serial_out_pin(tx), .o_serial_out_oe(txoe), .o_rts_bclk_pin(rb), .o_rts_bclk_oe(rboe),
    .o_cts(ocs), .o_rx_data(rxd), .o_core_run(run), .o_core_abort(abt),
    .o_port_override(ovr), .o_wake_bit(wk), .o_receive_irq_flag(flg));
  upw_far_end u_upw_far_end (.i_clk(clk), .i_brk(brk), .o_rx(rx), .o_cts(cts));
  task automatic chk(input string n, input logic e, input logic g);
    check_count++;
    if (e !== g) begin
      error_cnt++;
      $display("[FAIL] %s exp %b got %b", n, e, g);
    end
  endtask : chk
  task automatic complete_run;
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 1000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    {rst, wdt, slp, idl, wset, wclr, iclr, brk} = 8'h80;
    ctl = '0;
    core = '0;
    void'($urandom(32'hF308A005));
    step(2);
    rst = 1'b0;
    repeat (60) begin
      ctl = 8'($urandom);
      if ($urandom_range(1)) ctl[7:5] = 3'h7;
      ctl.loopback_enable_bit = 1'b0;
      core = 4'($urandom);
      {slp, idl} = 2'($urandom);
      step(1);
      h = slp | (idl & ctl.stop_in_idle_bit);
      own = &ctl[7:5];
      chk("override", own, ovr);
      chk("tx_oe", own, txoe);
      if (h) chk("tx_sleep", 1'b1, tx);
      else chk("tx_run", core.tx_data, tx);
      chk("abort", h, abt);
      chk("run", own & ~h, run);
      if (h) chk("rts_sleep", 1'b0, rb);
      if (own && ctl.pin_usage_field inside {UPW_USE_RTS, UPW_USE_RTS_CTS}) chk("rts_oe", 1'b1, rboe);
      if (own && !h && ctl.pin_usage_field == UPW_USE_BCLK) chk("bclk", core.baud16, rb);
    end
    // Wake from sleep by a break on the line, then release
    {slp, idl} = 2'h0;
    ctl = 8'hE1;
    core = '0;
    {wset, iclr} = 2'h3;
    step(1);
    iclr = 1'b0;
    chk("flag_clear", 1'b0, flg);
    // Wake bit left alone until the line rises again
    {wset, slp, brk} = 3'h3;
    step(8);
    chk("wake_irq", 1'b1, flg);
    chk("rx_quiet", 1'b1, rxd);
    brk = 1'b0;
    step(8);
    chk("wake_clear", 1'b0, wk);
    {wdt, iclr} = 2'h3;
    step(1);
    iclr = 1'b0;
    step(1);
    chk("wdt_keep", 1'b1, flg);
    {wdt, rst} = 2'h1;
    step(1);
    rst = 1'b0;
    chk("rst_flag", 1'b0, flg);
    ctl = 8'h61;
    wset = 1'b1;
    step(1);
    {wset, brk} = 2'h1;
    step(8);
    chk("wake_off", 1'b0, flg);
    complete_run();
  end
endmodule : uart_pin_power_wake_control_tb
